// [pkg/psh_pkg.sv]
// Purpose: Shared constants and types for the pad sleep/hold multiplexer.
// Assumes: One 50 MHz clock; register index addressing on a plain port.
// Notes:   Register offsets are word indices on the plain register port.
package psh_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int PAD_COUNT    = 40;
    localparam int LP_COUNT     = 18;
    localparam int LP_FIRST_PAD = 22;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;
    localparam int HOLD_SPLIT   = 32;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] LP_BASE   = 8'h00;
    localparam logic [ADDR_W-1:0] PAD_BASE  = 8'h40;
    localparam logic [ADDR_W-1:0] HOLD_LO   = 8'h80;
    localparam logic [ADDR_W-1:0] HOLD_HI   = 8'h81;
    localparam logic [ADDR_W-1:0] SIG_QUERY = 8'h90;
    localparam logic [ADDR_W-1:0] STATUS    = 8'h91;

    // ************************************************************
    // Field layouts
    // ************************************************************
    typedef struct packed {
        logic wake_en;
        logic oe;
        logic out;
        logic route_sel;
    } psh_lp_cfg_type;

    typedef struct packed {
        logic       sleep_oe;
        logic       sleep_pd;
        logic       sleep_pu;
        logic [1:0] sleep_drv;
        logic       normal_pd;
        logic       normal_pu;
        logic [1:0] normal_drv;
        logic       sleep_sel;
    } psh_pad_cfg_type;

    typedef struct packed {
        logic [1:0] drv;
        logic       pu;
        logic       pd;
        logic       oe;
        logic       out;
    } psh_pad_ctrl_type;

    typedef struct packed {
        logic direct;
        logic has_out;
        logic has_in;
    } psh_sig_info_type;

    localparam int LP_CFG_W   = $bits(psh_lp_cfg_type);
    localparam int PAD_CFG_W  = $bits(psh_pad_cfg_type);
    localparam int SIG_INFO_W = $bits(psh_sig_info_type);
    localparam int SIG_IDX_W  = 8;
    localparam int LP_IN_BIT  = 4;
    localparam int SIG_IDX_LSB = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam psh_lp_cfg_type   LP_CFG_RESET   = 4'h1;
    localparam psh_pad_cfg_type  PAD_CFG_RESET  = 10'h004;
    localparam psh_pad_ctrl_type PAD_CTRL_RESET = 6'h00;

endpackage : psh_pkg

// [src/psh_pad_hold_cell.sv]
// Purpose: Per-pad hold latch living in the always-on domain.
// Assumes: power_on_reset is the only reset of the always-on domain.
// Notes:   Core and system resets never reach this cell.
`timescale 1ns/100ps

module psh_pad_hold_cell (
    input  wire logic                      clk,
    input  wire logic                      power_on_reset,
    input  wire logic                      hold_we,
    input  wire logic                      hold_wdata,
    input  wire psh_pkg::psh_pad_ctrl_type live,
    output      psh_pkg::psh_pad_ctrl_type pad,
    output      logic                      hold
);
    import psh_pkg::*;

    typedef struct packed {
        logic             hold;
        psh_pad_ctrl_type pad;
    } psh_hold_state_type;

    psh_hold_state_type state;
    psh_hold_state_type next_state;

    always_comb begin
        next_state = state;
        if (hold_we) begin
            next_state.hold = hold_wdata;
        end
        // While held the pad copy stops following the live controls.
        if (!state.hold) begin
            next_state.pad = live;
        end
    end

    // Only the always-on reset clears the latch, so a held pad survives others.
    always_ff @(posedge clk or posedge power_on_reset) begin
        if (power_on_reset) begin
            state <= '{hold: 1'b0, pad: PAD_CTRL_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign pad  = state.pad;
    assign hold = state.hold;

endmodule : psh_pad_hold_cell

// [src/psh_pad_mux.sv]
// Purpose: Route select for low-power pads, light-sleep override and hold for all pads.
// Assumes: Inputs synchronous to clk; light_sleep/deep_sleep are levels.
// Notes:   Low-power pins are numbered separately from pads.
`timescale 1ns/100ps

module psh_pad_mux (
    input  wire logic                                           clk,
    input  wire logic                                           reset,
    input  wire logic                                           power_on_reset,
    input  wire logic [psh_pkg::ADDR_W-1:0]                     addr,
    input  wire logic [psh_pkg::DATA_W-1:0]                     wdata,
    input  wire logic                                           write_en,
    input  wire logic                                           read_en,
    output      logic [psh_pkg::DATA_W-1:0]                     rdata,
    input  wire logic                                           light_sleep,
    input  wire logic                                           deep_sleep,
    input  wire logic [psh_pkg::PAD_COUNT-1:0]                  matrix_out,
    input  wire logic [psh_pkg::PAD_COUNT-1:0]                  matrix_oe,
    input  wire logic [psh_pkg::PAD_COUNT-1:0]                  pad_in,
    output      psh_pkg::psh_pad_ctrl_type [psh_pkg::PAD_COUNT-1:0] pad_ctrl,
    output      logic [psh_pkg::PAD_COUNT-1:0]                  matrix_in,
    output      logic [psh_pkg::LP_COUNT-1:0]                   lp_in,
    output      logic                                           wake_req
);
    import psh_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        psh_lp_cfg_type  [LP_COUNT-1:0]  lp;
        psh_pad_cfg_type [PAD_COUNT-1:0] cfg;
        logic [LP_COUNT-1:0]             lp_drive_out;
        logic [LP_COUNT-1:0]             lp_drive_oe;
        logic [PAD_COUNT-1:0]            matrix_in;
        logic [LP_COUNT-1:0]             lp_in;
        logic                            wake;
        logic [SIG_IDX_W-1:0]            sig_index;
        logic [DATA_W-1:0]               rdata;
    } psh_state_type;

    psh_state_type                    state;
    psh_state_type                    next_state;
    psh_pad_ctrl_type [PAD_COUNT-1:0] live_ctrl;
    psh_pad_ctrl_type [PAD_COUNT-1:0] held_ctrl;
    logic [PAD_COUNT-1:0]             hold_bits;
    logic [PAD_COUNT-1:0]             hold_we;
    logic [LP_COUNT-1:0]              lp_routed;

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base,
                                      input int                count);
        int offset;
        offset = int'(a) - int'(base);
        return (offset >= 0) && (offset < count);
    endfunction : in_block

    // Pads from LP_FIRST_PAD upward carry the low-power pins in order.
    function automatic logic pad_is_lp(input int pad);
        return (pad >= LP_FIRST_PAD) && (pad < LP_FIRST_PAD + LP_COUNT);
    endfunction : pad_is_lp

    function automatic int pad_to_lp(input int pad);
        return pad - LP_FIRST_PAD;
    endfunction : pad_to_lp

    function automatic int lp_to_pad(input int lp);
        return lp + LP_FIRST_PAD;
    endfunction : lp_to_pad

    function automatic psh_sig_info_type sig_info(input logic [SIG_IDX_W-1:0] idx);
        psh_sig_info_type r;
        r = '0;
        if (idx inside {[8'h00:8'h12], [8'h17:8'h24], [8'h3d:8'h5a],
                        [8'h5f:8'h79], [8'h8c:8'h9b], [8'ha4:8'hac]}) begin
            r.has_in  = 1'b1;
            r.has_out = 1'b1;
        end
        if (idx inside {8'h25, [8'h5b:8'h5e], [8'h9c:8'ha3]}) begin
            r.has_out = 1'b1;
        end
        if (idx inside {[8'h27:8'h3a], [8'h7a:8'h7c]}) begin
            r.has_in = 1'b1;
        end
        if (idx inside {[8'h00:8'h05], [8'h08:8'h0f], [8'h11:8'h12],
                        [8'h3f:8'h44]}) begin
            r.direct = 1'b1;
        end
        return r;
    endfunction : sig_info

    // ************************************************************
    // Live pad controls
    // ************************************************************
    always_comb begin
        for (int p = 0; p < PAD_COUNT; p++) begin
            psh_pad_cfg_type c;
            logic            use_sleep;
            c         = state.cfg[p];
            use_sleep = c.sleep_sel && light_sleep;
            live_ctrl[p].out = matrix_out[p];
            if (use_sleep) begin
                live_ctrl[p].drv = c.sleep_drv;
                live_ctrl[p].pu  = c.sleep_pu;
                live_ctrl[p].pd  = c.sleep_pd;
                live_ctrl[p].oe  = c.sleep_oe;
            end else begin
                live_ctrl[p].drv = c.normal_drv;
                live_ctrl[p].pu  = c.normal_pu;
                live_ctrl[p].pd  = c.normal_pd;
                live_ctrl[p].oe  = matrix_oe[p];
            end
            if (pad_is_lp(p)) begin
                if (!state.lp[pad_to_lp(p)].route_sel) begin
                    live_ctrl[p].out = state.lp_drive_out[pad_to_lp(p)];
                    live_ctrl[p].oe  = state.lp_drive_oe[pad_to_lp(p)];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < LP_COUNT; i++) begin
            lp_routed[i] = !state.lp[i].route_sel;
        end
    end

    // ************************************************************
    // Register file and input routing
    // ************************************************************
    always_comb begin
        logic [ADDR_W-1:0] lp_off;
        logic [ADDR_W-1:0] pad_off;
        logic              wake_now;
        next_state = state;
        lp_off     = addr - LP_BASE;
        pad_off    = addr - PAD_BASE;
        wake_now   = 1'b0;

        if (write_en) begin
            if (in_block(addr, LP_BASE, LP_COUNT)) begin
                next_state.lp[lp_off] = wdata[LP_CFG_W-1:0];
            end
            if (in_block(addr, PAD_BASE, PAD_COUNT)) begin
                next_state.cfg[pad_off] = wdata[PAD_CFG_W-1:0];
            end
            if (addr == SIG_QUERY) begin
                next_state.sig_index = wdata[SIG_IDX_W-1:0];
            end
        end

        // Deep sleep freezes the low-power drive so software cannot disturb it.
        if (!deep_sleep) begin
            for (int i = 0; i < LP_COUNT; i++) begin
                next_state.lp_drive_out[i] = state.lp[i].out;
                next_state.lp_drive_oe[i]  = state.lp[i].oe;
            end
        end

        for (int p = 0; p < PAD_COUNT; p++) begin
            next_state.matrix_in[p] = pad_in[p];
        end
        for (int i = 0; i < LP_COUNT; i++) begin
            next_state.lp_in[i] = 1'b0;
            if (lp_routed[i]) begin
                next_state.matrix_in[lp_to_pad(i)] = 1'b0;
                next_state.lp_in[i] = pad_in[lp_to_pad(i)];
                if (state.lp[i].wake_en && pad_in[lp_to_pad(i)]) begin
                    wake_now = 1'b1;
                end
            end
        end
        next_state.wake = deep_sleep && wake_now;

        next_state.rdata = '0;
        if (read_en) begin
            if (in_block(addr, LP_BASE, LP_COUNT)) begin
                next_state.rdata[LP_CFG_W-1:0] = state.lp[lp_off];
                next_state.rdata[LP_IN_BIT]    = pad_in[lp_to_pad(int'(lp_off))];
            end else if (in_block(addr, PAD_BASE, PAD_COUNT)) begin
                next_state.rdata[PAD_CFG_W-1:0] = state.cfg[pad_off];
            end else if (addr == HOLD_LO) begin
                next_state.rdata = hold_bits[HOLD_SPLIT-1:0];
            end else if (addr == HOLD_HI) begin
                next_state.rdata[PAD_COUNT-HOLD_SPLIT-1:0] =
                    hold_bits[PAD_COUNT-1:HOLD_SPLIT];
            end else if (addr == SIG_QUERY) begin
                next_state.rdata[SIG_INFO_W-1:0] = sig_info(state.sig_index);
                next_state.rdata[SIG_IDX_LSB +: SIG_IDX_W] = state.sig_index;
            end else if (addr == STATUS) begin
                next_state.rdata[2:0] = {state.wake, deep_sleep, light_sleep};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state              <= '0;
            state.lp           <= {LP_COUNT{LP_CFG_RESET}};
            state.cfg          <= {PAD_COUNT{PAD_CFG_RESET}};
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Hold cells
    // ************************************************************
    generate
        for (genvar p = 0; p < PAD_COUNT; p++) begin : g_hold
            localparam logic [ADDR_W-1:0] HOLD_ADDR =
                (p < HOLD_SPLIT) ? HOLD_LO : HOLD_HI;
            localparam int HOLD_BIT = p % HOLD_SPLIT;
            assign hold_we[p] = write_en && (addr == HOLD_ADDR);
            psh_pad_hold_cell u_cell (
                .clk            (clk),
                .power_on_reset (power_on_reset),
                .hold_we        (hold_we[p]),
                .hold_wdata     (wdata[HOLD_BIT]),
                .live           (live_ctrl[p]),
                .pad            (held_ctrl[p]),
                .hold           (hold_bits[p])
            );
        end
    endgenerate

    assign pad_ctrl  = held_ctrl;
    assign matrix_in = state.matrix_in;
    assign lp_in     = state.lp_in;
    assign wake_req  = state.wake;
    assign rdata     = state.rdata;

endmodule : psh_pad_mux

// [verification/psh_checker.sv]
// Purpose: Port-level checks of the pad sleep/hold multiplexer.
// Assumes: Sees only the top ports; one clock, core reset async high.
// Notes:   Bound into every psh_pad_mux instance.
`timescale 1ns/100ps

module psh_checker (
    input wire logic                         clk,
    input wire logic                         reset,
    input wire logic [psh_pkg::ADDR_W-1:0]   addr,
    input wire logic                         read_en,
    input wire logic [psh_pkg::DATA_W-1:0]   rdata,
    input wire logic                         light_sleep,
    input wire logic                         deep_sleep,
    input wire logic [psh_pkg::PAD_COUNT-1:0] pad_in,
    input wire logic [psh_pkg::PAD_COUNT-1:0] matrix_in,
    input wire logic [psh_pkg::LP_COUNT-1:0] lp_in,
    input wire logic                         wake_req
);
    import psh_pkg::*;
    // ********************************************************
    // Properties
    // ********************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    idle_rdata_a: assert property (!$past(read_en) |-> rdata == '0)
        else $error("read data not zero outside answer cycle");
    unmapped_read_a: assert property ($past(read_en) && $past(addr) == 8'hff |-> rdata == '0)
        else $error("unmapped index read not zero");
    lp_word_a: assert property ($past(read_en) && $past(addr) < 8'h12 |-> rdata[31:5] == '0)
        else $error("low-power word has stray bits");
    status_mode_a: assert property ($past(read_en) && $past(addr) == STATUS
        |-> rdata[1:0] == {$past(deep_sleep), $past(light_sleep)})
        else $error("status mode bits wrong");
    wake_cause_a: assert property (wake_req |-> $past(deep_sleep) && (|lp_in))
        else $error("wake request without cause");
    route_split_a: assert property ((lp_in & matrix_in[39:22]) == '0)
        else $error("pad input seen on both paths");
    normal_input_a: assert property (!$past(reset) |-> matrix_in[21:0] == $past(pad_in[21:0]))
        else $error("ordinary pad input not passed on");
    reset_route_a: assert property ($fell(reset) |-> lp_in == '0 ##1 lp_in == '0)
        else $error("pin routed low-power after reset");
endmodule : psh_checker

bind psh_pad_mux psh_checker i_psh_checker (.clk(clk), .reset(reset), .addr(addr),
    .read_en(read_en), .rdata(rdata), .light_sleep(light_sleep), .deep_sleep(deep_sleep),
    .pad_in(pad_in), .matrix_in(matrix_in), .lp_in(lp_in), .wake_req(wake_req));

// [verification/psh_far_side.sv]
// Purpose: Model of the routing matrix and pad levels facing the block.
// Assumes: Lines change only just after a rising edge.
// Notes:   With steady low every line takes a fresh random value each cycle, as live traffic would.
`timescale 1ns/100ps

module psh_far_side (
    input  wire logic        clk,
    input  wire logic        steady,
    input  wire logic [39:0] set_out,
    input  wire logic [39:0] set_oe,
    input  wire logic [39:0] set_in,
    output      logic [39:0] matrix_out,
    output      logic [39:0] matrix_oe,
    output      logic [39:0] pad_in
);
    always @(posedge clk) begin
        if (steady) begin
            matrix_out <= set_out;
            matrix_oe  <= set_oe;
            pad_in     <= set_in;
        end else begin
            matrix_out <= 40'({$urandom, $urandom});
            matrix_oe  <= 40'({$urandom, $urandom});
            pad_in     <= 40'({$urandom, $urandom});
        end
    end
endmodule : psh_far_side

// [verification/pad_sleep_hold_mux_tb.sv]
// Purpose: Self-checking bench for the pad sleep/hold multiplexer.
// Assumes: 50 MHz clock; plain register port with one-cycle strobes.
// Notes:   Expected results are queued and compared by a monitor process.
`timescale 1ns/100ps

module pad_sleep_hold_mux_tb;
    import psh_pkg::*;
    logic                    clk = 0, reset = 1, power_on_reset = 1, write_en = 0, read_en = 0;
    logic                    light_sleep = 0, deep_sleep = 0, steady = 1, probe = 0, rd_seen = 0;
    logic                    wake_req;
    logic                    probe_in = 0;
    logic [7:0]              addr = '0;
    logic [31:0]             wdata = '0, rdata;
    logic [39:0]             set_out = '0, set_oe = '0, set_in = '0;
    logic [39:0]             matrix_out, matrix_oe, pad_in, matrix_in;
    logic [17:0]             lp_in;
    logic [5:0]              e;
    psh_pad_ctrl_type [39:0] pad_ctrl;
    int                      probe_pad = 0, fail_count = 0, samples_checked = 0;
    int                      idx[6] = '{14, 16, 37, 39, 58, 63};
    logic [2:0]              inf[6] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h1, 3'h7};
    logic [31:0]             exp_q[$];

    always #10 clk = ~clk;

    psh_far_side i_psh_far_side (.clk(clk), .steady(steady), .set_out(set_out), .set_oe(set_oe),
        .set_in(set_in), .matrix_out(matrix_out), .matrix_oe(matrix_oe), .pad_in(pad_in));
    psh_pad_mux i_psh_pad_mux (.clk(clk), .reset(reset), .power_on_reset(power_on_reset),
        .addr(addr), .wdata(wdata), .write_en(write_en), .read_en(read_en), .rdata(rdata),
        .light_sleep(light_sleep), .deep_sleep(deep_sleep), .matrix_out(matrix_out),
        .matrix_oe(matrix_oe), .pad_in(pad_in), .pad_ctrl(pad_ctrl), .matrix_in(matrix_in),
        .lp_in(lp_in), .wake_req(wake_req));

    // ********************************************************
    // Tasks and monitor
    // ********************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic compare(input logic [31:0] got);
        logic [31:0] x;
        x = exp_q.pop_front();
        samples_checked++;
        if (got !== x) begin
            fail_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, got);
        end
    endtask : compare

    // Strobes drop for a cycle after each access, so no signal is set twice in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        write_en <= 1'b1;
        cyc(1);
        write_en <= 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        addr <= a;
        read_en <= 1'b1;
        cyc(1);
        read_en <= 1'b0;
        cyc(1);
    endtask : rd

    task automatic chk_pad(input int p, input logic [5:0] x);
        cyc(2);
        exp_q.push_back({26'h0, x});
        probe_pad <= p;
        probe <= 1'b1;
        cyc(1);
        probe <= 1'b0;
    endtask : chk_pad

    // Expected word is {wake_req, lp_in, matrix_in of the first low-power pad}.
    task automatic chk_in(input logic [19:0] x);
        cyc(2);
        exp_q.push_back({12'h0, x});
        probe_in <= 1'b1;
        cyc(1);
        probe_in <= 1'b0;
    endtask : chk_in

    task automatic complete_run;
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        rd_seen <= read_en;
        if (rd_seen) compare(rdata);
        if (probe) compare({26'h0, pad_ctrl[probe_pad]});
        if (probe_in) compare({12'h0, wake_req, lp_in, matrix_in[LP_FIRST_PAD]});
    end

    initial begin
        cyc(3000);
        fail_count++;
        complete_run();
    end

    // ********************************************************
    // Scenarios
    // ********************************************************
    initial begin
        void'($urandom(32'h05eb));
        set_out <= 40'({$urandom, $urandom});
        set_oe <= 40'({$urandom, $urandom});
        set_in <= 40'({$urandom, $urandom}) & ~(40'h1 << 22);
        cyc(10);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        cyc(2);
        for (int i = 0; i < LP_COUNT; i++) begin
            rd(LP_BASE + 8'(i), {27'h0, set_in[LP_FIRST_PAD + i], 4'h1});
        end
        for (int i = 0; i < 6; i++) begin
            wr(SIG_QUERY, 32'(idx[i]));
            rd(SIG_QUERY, {16'h0, 8'(idx[i]), 5'h0, inf[i]});
        end
        rd(8'hff, '0);
        wr(PAD_BASE + 8'h05, 32'h36b);
        for (int m = 0; m < 4; m++) begin
            light_sleep <= m[0];
            if (m == 2) wr(PAD_BASE + 8'h05, 32'h36a);
            e = (m[0] && m < 2) ? {3'h6, 2'h3, set_out[5]} : {3'h3, 1'b0, set_oe[5], set_out[5]};
            chk_pad(5, e);
        end
        rd(STATUS, 32'h1);
        light_sleep <= 1'b0;
        wr(LP_BASE, 32'he);
        chk_pad(22, 6'h23);
        rd(LP_BASE, 32'he);
        deep_sleep <= 1'b1;
        wr(LP_BASE, 32'h8);
        chk_pad(22, 6'h23);
        set_in[22] <= 1'b1;
        chk_in({1'b1, 18'h1, 1'b0});
        rd(STATUS, 32'h6);
        deep_sleep <= 1'b0;
        wr(HOLD_HI, 32'h80);
        rd(HOLD_HI, 32'h80);
        wr(HOLD_LO, 32'h20);
        rd(HOLD_LO, 32'h20);
        steady <= 1'b0;
        wr(PAD_BASE + 8'h05, 32'h7);
        chk_pad(5, e);
        reset <= 1'b1;
        cyc(3);
        reset <= 1'b0;
        steady <= 1'b1;
        chk_pad(5, e);
        chk_pad(6, {2'h2, 2'h0, set_oe[6], set_out[6]});
        wr(HOLD_LO, 32'h0);
        chk_pad(5, {2'h2, 2'h0, set_oe[5], set_out[5]});
        complete_run();
    end
endmodule : pad_sleep_hold_mux_tb
